/* verilog/fesp_ctrl.sv */
// Contract
// - chip erase: six writes, last 10H@5555H
// - keep protect pin steady during sequences
// - trust full word 1 us later
// - status reads use address in region
// - confirm completion with two more reads
// - wait recovery after reset release
// - host supplies unlock prefixes (the controller writes the AAH@5555H, 55H@2AAAH prefixes itself)
// - query entry 98H@5555H, exit command
//
// Implementation choices: the plain strobed port and the placing of the registers.
module fesp_ctrl
  import fesp_pkg::*;
#(
  parameter int          ERASE_TIMEOUT_CYC = 1000000,
  parameter logic        BOOT_TOP          = 1'b0
) (
  // clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RESET_I,
  // register port
  input  wire logic [7:0]  ADDR_I,
  input  wire logic [31:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic [31:0]      RDATA_O,
  // flash pins
  output logic [21:0]      FL_ADDR_O,
  input  wire logic [15:0] FL_DQ_I,
  output logic [15:0]      FL_DQ_O,
  output logic             FL_DQ_OE_O,
  output logic             FL_CE_N_O,
  output logic             FL_WE_N_O,
  output logic             FL_OE_N_O,
  output logic             FL_WP_N_O,
  output logic             FL_RST_N_O
);

  typedef enum logic [3:0] {
    S_IDLE, S_SEQ, S_SEQ_W, S_POLL, S_POLL_W, S_SETTLE, S_FINAL, S_FINAL_W,
    S_ID0, S_ID0_W, S_ID1, S_ID1_W, S_EXIT, S_EXIT_W, S_RST, S_WAIT
  } fesp_state_t;

  fesp_state_t st_q;
  fesp_op_t    op_q;
  logic [21:0] addr_q;
  logic [15:0] wdata_q;
  logic [15:0] rdata_q;
  logic [15:0] id_man_q;
  logic [15:0] id_dev_q;
  logic [15:0] prev_q;
  logic        first_q;
  logic [1:0]  stable_q;
  logic [3:0]  idx_q;
  logic [31:0] tmo_q;
  logic [31:0] wait_q;
  logic        prot_q;
  logic        done_q;
  logic        refused_q;
  logic        timeout_q;
  logic        mismatch_q;
  logic        rst_n_q;
  logic        cyc_start;
  logic        cyc_write;
  logic [21:0] cyc_addr;
  logic [15:0] cyc_data;
  logic        cyc_done;
  logic [15:0] cyc_rdata;
  logic [37:0] step;
  logic        busy;
  logic        start_req;
  logic        clr_done;
  logic        in_boot;
  logic        poll_ok;
  logic        finish;

  assign busy      = (st_q != S_IDLE);
  assign start_req = WR_I && (ADDR_I == REG_CTRL) && !busy;
  assign clr_done  = WR_I && (ADDR_I == REG_STATUS) && WDATA_I[ST_DONE];
  assign step      = seq_word(op_q, idx_q, addr_q, wdata_q);
  assign in_boot   = BOOT_TOP ? (addr_q >= BOOT_HI_FIRST) : (addr_q <= BOOT_LO_LAST);
  assign finish    = busy && (st_q == S_WAIT) && (wait_q == 32'h0);

  // completion: toggle flag stopped and poll bit showing the final value
  always_comb begin
    poll_ok = (cyc_rdata[TOGGLE_BIT] == prev_q[TOGGLE_BIT]);
    if (op_q == OP_PROG)
      poll_ok = poll_ok && (cyc_rdata[POLL_BIT] == wdata_q[POLL_BIT]);
    else
      poll_ok = poll_ok && cyc_rdata[POLL_BIT];
  end

  // protect level only changes between operations
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) prot_q <= 1'b1;
    else if (WR_I && (ADDR_I == REG_PROT) && !busy) prot_q <= WDATA_I[0];
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      st_q       <= S_IDLE;
      op_q       <= OP_READ;
      addr_q     <= 22'h000000;
      wdata_q    <= 16'h0000;
      rdata_q    <= 16'h0000;
      id_man_q   <= 16'h0000;
      id_dev_q   <= 16'h0000;
      prev_q     <= 16'h0000;
      first_q    <= 1'b1;
      stable_q   <= 2'h0;
      idx_q      <= 4'h0;
      tmo_q      <= 32'h0;
      wait_q     <= 32'h0;
      refused_q  <= 1'b0;
      timeout_q  <= 1'b0;
      mismatch_q <= 1'b0;
      rst_n_q    <= 1'b1;
      cyc_start  <= 1'b0;
      cyc_write  <= 1'b0;
      cyc_addr   <= 22'h000000;
      cyc_data   <= 16'h0000;
    end else begin
      cyc_start <= 1'b0;
      if (WR_I && (ADDR_I == REG_ADDR) && !busy) addr_q <= WDATA_I[21:0];
      if (WR_I && (ADDR_I == REG_WDATA) && !busy) wdata_q <= WDATA_I[15:0];
      case (st_q)
        S_IDLE: begin
          if (start_req) begin
            op_q       <= fesp_op_t'(WDATA_I[2:0]);
            idx_q      <= 4'h0;
            refused_q  <= 1'b0;
            timeout_q  <= 1'b0;
            mismatch_q <= 1'b0;
            first_q    <= 1'b1;
            stable_q   <= 2'h0;
            case (fesp_op_t'(WDATA_I[2:0]))
              OP_READ: begin
                cyc_start <= 1'b1;
                cyc_write <= 1'b0;
                cyc_addr  <= addr_q;
                st_q      <= S_FINAL_W;
              end
              OP_CHIP_ERASE: begin
                // a protected part would drop it anyway, so do not issue
                if (!prot_q) begin
                  refused_q <= 1'b1;
                  st_q      <= S_WAIT;
                  wait_q    <= 32'h0;
                end else st_q <= S_SEQ;
              end
              OP_PROG: begin
                if (!prot_q && in_boot) begin
                  refused_q <= 1'b1;
                  st_q      <= S_WAIT;
                  wait_q    <= 32'h0;
                end else st_q <= S_SEQ;
              end
              OP_RESET: begin
                rst_n_q <= 1'b0;
                wait_q  <= 32'(RESET_PULSE_CYC - 1);
                st_q    <= S_RST;
              end
              default: st_q <= S_SEQ;
            endcase
          end
        end
        S_SEQ: begin
          // every program or erase carries its unlock prefix
          cyc_start <= 1'b1;
          cyc_write <= 1'b1;
          cyc_addr  <= step[37:16];
          cyc_data  <= step[15:0];
          st_q      <= S_SEQ_W;
        end
        S_SEQ_W: begin
          if (cyc_done) begin
            idx_q <= idx_q + 4'h1;
            if (idx_q + 4'h1 != seq_len(op_q)) st_q <= S_SEQ;
            else begin
              case (op_q)
                // status is valid only once the last write has ended
                OP_PROG: begin
                  tmo_q <= 32'(PROG_MAX_CYC);
                  st_q  <= S_POLL;
                end
                OP_CHIP_ERASE: begin
                  tmo_q <= 32'(ERASE_TIMEOUT_CYC);
                  st_q  <= S_POLL;
                end
                OP_ID: st_q <= S_ID0;
                OP_SUSPEND: begin
                  wait_q <= 32'(SUSPEND_CYC);
                  st_q   <= S_WAIT;
                end
                default: begin
                  wait_q <= 32'(ABORT_CYC);
                  st_q   <= S_WAIT;
                end
              endcase
            end
          end
        end
        S_POLL: begin
          cyc_start <= 1'b1;
          cyc_write <= 1'b0;
          cyc_addr  <= addr_q;
          st_q      <= S_POLL_W;
        end
        S_POLL_W: begin
          if (tmo_q != 32'h0) tmo_q <= tmo_q - 32'h1;
          if (cyc_done) begin
            prev_q  <= cyc_rdata;
            first_q <= 1'b0;
            if (!first_q && poll_ok) begin
              // two further agreeing reads before believing completion
              if (stable_q == 2'h2) begin
                wait_q <= 32'(SETTLE_CYC);
                st_q   <= S_SETTLE;
              end else begin
                stable_q <= stable_q + 2'h1;
                st_q     <= S_POLL;
              end
            end else if (tmo_q == 32'h0) begin
              timeout_q <= 1'b1;
              wait_q    <= 32'h0;
              st_q      <= S_WAIT;
            end else begin
              stable_q <= 2'h0;
              st_q     <= S_POLL;
            end
          end
        end
        S_SETTLE: begin
          if (wait_q == 32'h0) st_q <= S_FINAL;
          else wait_q <= wait_q - 32'h1;
        end
        S_FINAL: begin
          cyc_start <= 1'b1;
          cyc_write <= 1'b0;
          cyc_addr  <= addr_q;
          st_q      <= S_FINAL_W;
        end
        S_FINAL_W: begin
          if (cyc_done) begin
            rdata_q <= cyc_rdata;
            if (op_q == OP_PROG && cyc_rdata != wdata_q) mismatch_q <= 1'b1;
            if (op_q == OP_CHIP_ERASE && cyc_rdata != 16'hFFFF) mismatch_q <= 1'b1;
            wait_q <= 32'h0;
            st_q   <= S_WAIT;
          end
        end
        S_ID0: begin
          cyc_start <= 1'b1;
          cyc_write <= 1'b0;
          cyc_addr  <= ID_MAN_ADDR;
          st_q      <= S_ID0_W;
        end
        S_ID0_W: if (cyc_done) begin
          id_man_q <= cyc_rdata;
          st_q     <= S_ID1;
        end
        S_ID1: begin
          cyc_start <= 1'b1;
          cyc_write <= 1'b0;
          cyc_addr  <= ID_DEV_ADDR;
          st_q      <= S_ID1_W;
        end
        S_ID1_W: if (cyc_done) begin
          id_dev_q <= cyc_rdata;
          st_q     <= S_EXIT;
        end
        S_EXIT: begin
          cyc_start <= 1'b1;
          cyc_write <= 1'b1;
          cyc_addr  <= CMD_ADDR;
          cyc_data  <= CODE_EXIT;
          st_q      <= S_EXIT_W;
        end
        S_EXIT_W: if (cyc_done) begin
          wait_q <= 32'(ABORT_CYC);
          st_q   <= S_WAIT;
        end
        S_RST: begin
          if (wait_q == 32'h0) begin
            rst_n_q <= 1'b1;
            wait_q  <= 32'(RESET_RECOV_CYC);
            st_q    <= S_WAIT;
          end else wait_q <= wait_q - 32'h1;
        end
        S_WAIT: begin
          if (wait_q == 32'h0) st_q <= S_IDLE;
          else wait_q <= wait_q - 32'h1;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // completion flag: a new completion wins over a software clear
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) done_q <= 1'b0;
    else if (finish) done_q <= 1'b1;
    else if (clr_done || start_req) done_q <= 1'b0;
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) RDATA_O <= 32'h0;
    else if (RD_I) begin
      case (ADDR_I)
        REG_CTRL:   RDATA_O <= {29'h0, op_q};
        REG_ADDR:   RDATA_O <= {10'h0, addr_q};
        REG_WDATA:  RDATA_O <= {16'h0, wdata_q};
        REG_STATUS: RDATA_O <= {27'h0, mismatch_q, timeout_q, refused_q, done_q, busy};
        REG_RDATA:  RDATA_O <= {16'h0, rdata_q};
        REG_ID_MAN: RDATA_O <= {16'h0, id_man_q};
        REG_ID_DEV: RDATA_O <= {16'h0, id_dev_q};
        REG_PROT:   RDATA_O <= {31'h0, prot_q};
        default:    RDATA_O <= 32'h0;
      endcase
    end else RDATA_O <= 32'h0;
  end

  assign FL_WP_N_O  = prot_q;
  assign FL_RST_N_O = rst_n_q;

  fesp_cycle u_cycle (
    .clk_i      (CLK_I),
    .rst_i      (RESET_I),
    .start_i    (cyc_start),
    .write_i    (cyc_write),
    .addr_i     (cyc_addr),
    .data_i     (cyc_data),
    .done_o     (cyc_done),
    .rdata_o    (cyc_rdata),
    .fl_addr_o  (FL_ADDR_O),
    .fl_dq_i    (FL_DQ_I),
    .fl_dq_o    (FL_DQ_O),
    .fl_dq_oe_o (FL_DQ_OE_O),
    .fl_ce_n_o  (FL_CE_N_O),
    .fl_we_n_o  (FL_WE_N_O),
    .fl_oe_n_o  (FL_OE_N_O)
  );

endmodule : fesp_ctrl

/* verilog/fesp_pkg.sv */
package fesp_pkg;

  localparam int CLK_PERIOD_NS = 100;

  // flash word command interface
  localparam logic [21:0] CMD_ADDR         = 22'h005555;
  localparam logic [21:0] UNLOCK2_ADDR     = 22'h002AAA;
  localparam logic [21:0] ID_MAN_ADDR      = 22'h000000;
  localparam logic [21:0] ID_DEV_ADDR      = 22'h000001;
  localparam logic [21:0] BOOT_LO_LAST     = 22'h007FFF;
  localparam logic [21:0] BOOT_HI_FIRST    = 22'h3F8000;
  localparam logic [15:0] CODE_UNLOCK1     = 16'h00AA;
  localparam logic [15:0] CODE_UNLOCK2     = 16'h0055;
  localparam logic [15:0] CODE_ERASE_SETUP = 16'h0080;
  localparam logic [15:0] CODE_CHIP_ERASE  = 16'h0010;
  localparam logic [15:0] CODE_PROGRAM     = 16'h00A0;
  localparam logic [15:0] CODE_ID_ENTRY    = 16'h0090;
  localparam logic [15:0] CODE_QUERY_ENTRY = 16'h0098;
  localparam logic [15:0] CODE_EXIT        = 16'h00F0;
  localparam logic [15:0] CODE_SUSPEND     = 16'h00B0;
  localparam int          POLL_BIT         = 7;
  localparam int          TOGGLE_BIT       = 6;

  // times in ns and derived clock counts
  localparam int WE_LOW_NS       = 40;
  localparam int GLITCH_MIN_NS   = 5;
  localparam int READ_ACCESS_NS  = 90;
  localparam int READ_CYCLE_NS   = 90;
  localparam int SETTLE_NS       = 1000;
  localparam int PROG_MAX_NS     = 10000;
  localparam int SUSPEND_NS      = 20000;
  localparam int RESET_PULSE_NS  = 500;
  localparam int RESET_RECOV_NS  = 500;

  function automatic int ns_to_cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc_up

  localparam int WE_LOW_CYC      = ns_to_cyc_up((WE_LOW_NS > GLITCH_MIN_NS) ? WE_LOW_NS
                                                                             : GLITCH_MIN_NS + 1);
  localparam int READ_ACCESS_CYC = ns_to_cyc_up(READ_ACCESS_NS);
  localparam int ABORT_CYC       = ns_to_cyc_up(READ_CYCLE_NS);
  localparam int SETTLE_CYC      = ns_to_cyc_up(SETTLE_NS);
  localparam int PROG_MAX_CYC    = ns_to_cyc_up(PROG_MAX_NS);
  localparam int SUSPEND_CYC     = ns_to_cyc_up(SUSPEND_NS);
  localparam int RESET_PULSE_CYC = ns_to_cyc_up(RESET_PULSE_NS);
  localparam int RESET_RECOV_CYC = ns_to_cyc_up(RESET_RECOV_NS);

  // software register map (byte offsets)
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA  = 8'h10;
  localparam logic [7:0] REG_ID_MAN = 8'h14;
  localparam logic [7:0] REG_ID_DEV = 8'h18;
  localparam logic [7:0] REG_PROT   = 8'h1C;
  localparam int ST_BUSY    = 0;
  localparam int ST_DONE    = 1;
  localparam int ST_REFUSED = 2;
  localparam int ST_TIMEOUT = 3;
  localparam int ST_MISMATCH = 4;

  typedef enum logic [2:0] {
    OP_READ, OP_PROG, OP_CHIP_ERASE, OP_ID, OP_QRY_ENTER, OP_QRY_EXIT, OP_RESET, OP_SUSPEND
  } fesp_op_t;

  function automatic logic [3:0] seq_len(input fesp_op_t op);
    case (op)
      OP_PROG:       return 4'h4;
      OP_CHIP_ERASE: return 4'h6;
      OP_ID:         return 4'h3;
      OP_QRY_ENTER:  return 4'h3;
      OP_QRY_EXIT:   return 4'h1;
      OP_SUSPEND:    return 4'h1;
      default:       return 4'h0;
    endcase
  endfunction : seq_len

  // {address, data} of write number idx in the sequence of op
  function automatic logic [37:0] seq_word(input fesp_op_t op, input logic [3:0] idx,
                                           input logic [21:0] a, input logic [15:0] d);
    logic [37:0] w;
    w = {CMD_ADDR, CODE_EXIT};
    case (idx)
      4'h0, 4'h3: w = {CMD_ADDR, CODE_UNLOCK1};
      4'h1, 4'h4: w = {UNLOCK2_ADDR, CODE_UNLOCK2};
      default:    w = {CMD_ADDR, CODE_EXIT};
    endcase
    case (op)
      OP_PROG: begin
        if (idx == 4'h2) w = {CMD_ADDR, CODE_PROGRAM};
        if (idx == 4'h3) w = {a, d};
      end
      OP_CHIP_ERASE: begin
        if (idx == 4'h2) w = {CMD_ADDR, CODE_ERASE_SETUP};
        if (idx == 4'h5) w = {CMD_ADDR, CODE_CHIP_ERASE};
      end
      OP_ID:        if (idx == 4'h2) w = {CMD_ADDR, CODE_ID_ENTRY};
      OP_QRY_ENTER: if (idx == 4'h2) w = {CMD_ADDR, CODE_QUERY_ENTRY};
      OP_QRY_EXIT:  w = {CMD_ADDR, CODE_EXIT};
      OP_SUSPEND:   w = {CMD_ADDR, CODE_SUSPEND};
      default:      w = {CMD_ADDR, CODE_EXIT};
    endcase
    return w;
  endfunction : seq_word

endpackage : fesp_pkg

/* verilog/fesp_cycle.sv */
module fesp_cycle
  import fesp_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // request
  input  wire logic        start_i,
  input  wire logic        write_i,
  input  wire logic [21:0] addr_i,
  input  wire logic [15:0] data_i,
  output logic             done_o,
  output logic [15:0]      rdata_o,
  // flash pins
  output logic [21:0]      fl_addr_o,
  input  wire logic [15:0] fl_dq_i,
  output logic [15:0]      fl_dq_o,
  output logic             fl_dq_oe_o,
  output logic             fl_ce_n_o,
  output logic             fl_we_n_o,
  output logic             fl_oe_n_o
);

  typedef enum logic [1:0] {C_IDLE, C_SETUP, C_ACT, C_HOLD} fesp_cyc_t;

  fesp_cyc_t  st_q;
  logic [7:0] cnt_q;
  logic       wr_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q       <= C_IDLE;
      cnt_q      <= 8'h00;
      wr_q       <= 1'b0;
      done_o     <= 1'b0;
      rdata_o    <= 16'h0000;
      fl_addr_o  <= 22'h000000;
      fl_dq_o    <= 16'h0000;
      fl_dq_oe_o <= 1'b0;
      fl_ce_n_o  <= 1'b1;
      fl_we_n_o  <= 1'b1;
      fl_oe_n_o  <= 1'b1;
    end else begin
      done_o <= 1'b0;
      case (st_q)
        C_IDLE: begin
          if (start_i) begin
            st_q       <= C_SETUP;
            wr_q       <= write_i;
            fl_addr_o  <= addr_i;
            fl_dq_o    <= data_i;
            fl_dq_oe_o <= write_i;
            fl_ce_n_o  <= 1'b0;
            fl_oe_n_o  <= write_i;
          end
        end
        C_SETUP: begin
          st_q      <= C_ACT;
          fl_we_n_o <= ~wr_q;
          cnt_q     <= wr_q ? 8'(WE_LOW_CYC - 1) : 8'(READ_ACCESS_CYC - 1);
        end
        C_ACT: begin
          // strobe held well past the glitch filter, gate kept high while writing
          if (cnt_q == 8'h00) begin
            st_q      <= C_HOLD;
            fl_we_n_o <= 1'b1;
            fl_oe_n_o <= 1'b1;
            if (!wr_q) rdata_o <= fl_dq_i;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        C_HOLD: begin
          st_q       <= C_IDLE;
          fl_ce_n_o  <= 1'b1;
          fl_dq_oe_o <= 1'b0;
          done_o     <= 1'b1;
        end
        default: st_q <= C_IDLE;
      endcase
    end
  end

endmodule : fesp_cycle

/* sim/fesp_sva.sv */
module fesp_sva
  import fesp_pkg::*;
(
  // clock and reset
  input wire logic        CLK_I,
  input wire logic        RESET_I,
  // register port
  input wire logic        RD_I,
  input wire logic [31:0] RDATA_O,
  // flash pins
  input wire logic [21:0] FL_ADDR_O,
  input wire logic [15:0] FL_DQ_O,
  input wire logic        FL_DQ_OE_O,
  input wire logic        FL_CE_N_O,
  input wire logic        FL_WE_N_O,
  input wire logic        FL_OE_N_O,
  input wire logic        FL_WP_N_O,
  input wire logic        FL_RST_N_O
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dck @(posedge CLK_I);
  endclocking
  default disable iff (RESET_I);

  a_gate_we_excl: assert property (!FL_OE_N_O |-> FL_WE_N_O && !FL_DQ_OE_O)
    else $error("output gate low while writing");
  a_we_under_ce: assert property (!FL_WE_N_O |-> !FL_CE_N_O && FL_DQ_OE_O)
    else $error("write strobe without select or data");
  a_we_one_cyc: assert property ($fell(FL_WE_N_O) |=> FL_WE_N_O)
    else $error("write strobe width wrong");
  a_data_at_rise: assert property ($rose(FL_WE_N_O) |->
    !FL_CE_N_O && FL_DQ_OE_O && $stable(FL_DQ_O) && $stable(FL_ADDR_O))
    else $error("data or address moved in write cycle");
  a_wp_steady: assert property (!FL_CE_N_O |-> $stable(FL_WP_N_O))
    else $error("protect pin moved in bus cycle");
  a_rst_pulse: assert property ($fell(FL_RST_N_O) |-> !FL_RST_N_O [*5] ##1 FL_RST_N_O)
    else $error("reset pulse length wrong");
  a_rst_recover: assert property ($rose(FL_RST_N_O) |-> FL_CE_N_O [*5])
    else $error("access before reset recovery");
  a_rst_quiet: assert property (!FL_RST_N_O |-> FL_CE_N_O && FL_WE_N_O && FL_OE_N_O)
    else $error("strobe active during reset pulse");
  a_rd_window: assert property (!$past(RD_I) |-> RDATA_O == 32'h0)
    else $error("read data outside its cycle");

  c_write: cover property ($fell(FL_WE_N_O));
  c_reset: cover property ($fell(FL_RST_N_O));
  c_read: cover property ($fell(FL_OE_N_O) ##2 $rose(FL_OE_N_O));
endmodule : fesp_sva

bind fesp_ctrl fesp_sva u_sva (
  .CLK_I(CLK_I), .RESET_I(RESET_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
  .FL_ADDR_O(FL_ADDR_O), .FL_DQ_O(FL_DQ_O), .FL_DQ_OE_O(FL_DQ_OE_O),
  .FL_CE_N_O(FL_CE_N_O), .FL_WE_N_O(FL_WE_N_O), .FL_OE_N_O(FL_OE_N_O),
  .FL_WP_N_O(FL_WP_N_O), .FL_RST_N_O(FL_RST_N_O)
);

/* sim/fesp_flash_model.sv */
module fesp_flash_model
  import fesp_pkg::*;
#(
  parameter logic [15:0] MAN_ID = 16'h005A,  // arbitrary value
  parameter logic [15:0] DEV_ID = 16'h1C3D,  // arbitrary value
  parameter logic [15:0] QRY_W  = 16'h0051
) (
  // controller side pins
  input  wire logic [21:0] addr_i,
  input  wire logic [15:0] dq_i,
  input  wire logic        ce_n_i,
  input  wire logic        we_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        wp_n_i,
  input  wire logic        rst_n_i,
  // device data drive
  output logic [15:0]      dq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [int];
  logic [21:0] a_q;
  logic [21:0] pa = 22'h0;
  logic [15:0] wd = 16'h0;
  logic [2:0]  step = 3'h0;
  logic [1:0]  mode = 2'h0;
  logic        ers = 1'b0;
  logic        tog = 1'b0;
  logic        tg2 = 1'b0;
  time         t_we, t_rs;
  time         t_end = 0;
  int          n_wr = 0;
  int          n_rst = 0;

  function automatic logic [15:0] word(input logic [21:0] a);
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction : word

  task automatic cmd(input logic [21:0] a, input logic [15:0] d);
    n_wr++;
    if (step == 3'h7) begin
      step = 3'h0;
      wd = d;
      pa = a;
      ers = 1'b0;
      if (wp_n_i || a > BOOT_LO_LAST) begin
        mem[a] = word(a) & d;
        t_end = $time + 3000;
      end
    end else if (d == CODE_EXIT) begin
      mode = 2'h0;
      step = 3'h0;
    end else if ((step == 3'h0 || step == 3'h3) && a == CMD_ADDR && d == CODE_UNLOCK1)
      step++;
    else if ((step == 3'h1 || step == 3'h4) && a == UNLOCK2_ADDR && d == CODE_UNLOCK2)
      step++;
    else if (step == 3'h2 && d == CODE_PROGRAM)
      step = 3'h7;
    else if (step == 3'h2 && d == CODE_ERASE_SETUP)
      step = 3'h3;
    else if (step == 3'h2 && (d == CODE_ID_ENTRY || d == CODE_QUERY_ENTRY)) begin
      mode = (d == CODE_ID_ENTRY) ? 2'h1 : 2'h2;
      step = 3'h0;
    end else if (step == 3'h5 && a == CMD_ADDR && d == CODE_CHIP_ERASE) begin
      step = 3'h0;
      if (wp_n_i) begin
        mem.delete();
        ers = 1'b1;
        t_end = $time + 20000;
      end
    end else if (d == CODE_SUSPEND)
      step = 3'h0;
    else
      step = 3'h0;
  endtask : cmd

  always @(negedge we_n_i) begin
    t_we = $time;
    a_q = addr_i;
  end
  // short pulses, inhibit levels and busy time all drop the write
  always @(posedge we_n_i)
    if (!ce_n_i && oe_n_i && rst_n_i && $time >= t_end && $time - t_we >= GLITCH_MIN_NS)
      cmd(a_q, dq_i);

  always @(negedge oe_n_i) begin
    #1;
    if (!ce_n_i && rst_n_i) begin
      tog = ~tog;
      if (ers && $time < t_end)
        tg2 = ~tg2;
      // program status only shows at the word being written
      if ($time < t_end && (ers || addr_i == pa))
        dq_o = ers ? {9'h0, tog, 3'h0, tg2, 2'h0} : {8'h0, ~wd[7], tog, 6'h0};
      else if (mode == 2'h2)
        dq_o = QRY_W;
      else if (mode == 2'h1 && addr_i < 22'h2)
        dq_o = addr_i[0] ? DEV_ID : MAN_ID;
      else if ($time < t_end + SETTLE_NS)
        dq_o = word(addr_i) ^ 16'hFF7F;
      else
        dq_o = word(addr_i);
    end
  end
  // released bus shows the inverse of the last word
  always @(posedge oe_n_i)
    dq_o = ~dq_o;

  always @(negedge rst_n_i)
    t_rs = $time;
  always @(posedge rst_n_i)
    if ($time - t_rs >= RESET_PULSE_NS) begin
      mode = 2'h0;
      step = 3'h0;
      t_end = 0;
      n_rst++;
    end
endmodule : fesp_flash_model

/* sim/fesp_ctrl_bench.sv */
module fesp_ctrl_bench
  import fesp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, wr, rd;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, s;
  logic [21:0] fa;
  logic [15:0] fdo, fdi, mdq;
  logic        dq_oe, ce_n, we_n, oe_n, wp_n, rst_n;
  int          err_count = 0;
  int          checks = 0;
  int          cyc = 0;
  int          n;

  assign fdi = dq_oe ? fdo : mdq;

  fesp_ctrl #(.ERASE_TIMEOUT_CYC(2000)) u_dut (
    .CLK_I(clk), .RESET_I(rst), .ADDR_I(adr), .WDATA_I(wdat), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdat), .FL_ADDR_O(fa), .FL_DQ_I(fdi), .FL_DQ_O(fdo), .FL_DQ_OE_O(dq_oe),
    .FL_CE_N_O(ce_n), .FL_WE_N_O(we_n), .FL_OE_N_O(oe_n), .FL_WP_N_O(wp_n),
    .FL_RST_N_O(rst_n)
  );
  fesp_flash_model u_fl (
    .addr_i(fa), .dq_i(fdo), .ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n),
    .wp_n_i(wp_n), .rst_n_i(rst_n), .dq_o(mdq)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t ns: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic rw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr   <= 1'b1;
    adr  <= a;
    wdat <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : rw

  task automatic rr(input logic [7:0] a);
    @(posedge clk);
    rd  <= 1'b1;
    adr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    s = rdat;
  endtask : rr

  task automatic wt();
    for (int i = 0; i < 3000; i++) begin
      rr(REG_STATUS);
      if (s[ST_BUSY] === 1'b0)
        break;
    end
    chk({31'h0, s[ST_BUSY]}, 32'h0);
  endtask : wt

  task automatic run(input logic [2:0] op);
    rw(REG_CTRL, {29'h0, op});
    wt();
  endtask : run

  task automatic t_reset();
    #1;
    chk({26'h0, ce_n, we_n, oe_n, dq_oe, wp_n, rst_n}, 32'h3B);
    rr(REG_PROT);
    chk(s, 32'h1);
    rr(8'h20);
    chk(s, 32'h0);
  endtask : t_reset

  task automatic t_program();
    rw(REG_ADDR, 32'h1234);
    rw(REG_WDATA, 32'hA5C3);
    rw(REG_CTRL, 32'h1);
    rw(REG_ADDR, 32'h0777);
    wt();
    chk(s & 32'h1F, 32'h2);
    rr(REG_RDATA);
    chk(s, 32'hA5C3);
    rr(REG_ADDR);
    chk(s, 32'h1234);
    chk({16'h0, u_fl.word(22'h1234)}, 32'hA5C3);
    // reprogram without erase: cells only clear, so the word reads back wrong
    rw(REG_WDATA, 32'h5A5A);
    run(3'h1);
    chk(s & 32'h1F, 32'h12);
    rr(REG_RDATA);
    chk(s, 32'h0042);
    run(3'h3);
    rr(REG_ID_MAN);
    chk(s, {16'h0, u_fl.MAN_ID});
    rr(REG_ID_DEV);
    chk(s, {16'h0, u_fl.DEV_ID});
    chk({30'h0, u_fl.mode}, 32'h0);
  endtask : t_program

  task automatic t_protect();
    rw(REG_PROT, 32'h0);
    rw(REG_ADDR, 32'h7FFF);
    rw(REG_WDATA, 32'h0);
    chk({31'h0, wp_n}, 32'h0);
    n = u_fl.n_wr;
    run(3'h1);
    chk({31'h0, s[ST_REFUSED]}, 32'h1);
    run(3'h2);
    chk({31'h0, s[ST_REFUSED]}, 32'h1);
    chk(u_fl.n_wr, n);
    rw(REG_ADDR, 32'h8000);
    rw(REG_WDATA, 32'h1111);
    run(3'h1);
    chk({s[ST_MISMATCH], s[ST_DONE]}, 32'h1);
    chk({16'h0, u_fl.word(22'h8000)}, 32'h1111);
    rw(REG_PROT, 32'h1);
    run(3'h2);
    chk({s[ST_MISMATCH], s[ST_DONE]}, 32'h1);
    chk({u_fl.word(22'h1234), u_fl.word(22'h8000)}, 32'hFFFFFFFF);
  endtask : t_protect

  task automatic t_query();
    run(3'h4);
    chk({30'h0, u_fl.mode}, 32'h2);
    rw(REG_ADDR, 32'h10);
    run(3'h0);
    rr(REG_RDATA);
    chk(s, {16'h0, u_fl.QRY_W});
    run(3'h5);
    run(3'h0);
    rr(REG_RDATA);
    chk(s, 32'hFFFF);
    run(3'h4);
    n = u_fl.n_rst;
    run(3'h6);
    chk({30'h0, u_fl.mode}, 32'h0);
    chk(u_fl.n_rst, n + 1);
    run(3'h7);
    chk({31'h0, s[ST_DONE]}, 32'h1);
  endtask : t_query

  task automatic report_and_stop();
    if (err_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 50000) begin
      err_count++;
      $display("ERROR %0t ns: run too long", $time);
      report_and_stop();
    end
  end

  initial begin
    rst  = 1'b1;
    wr   = 1'b0;
    rd   = 1'b0;
    adr  = 8'h00;
    wdat = 32'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_program();
    t_protect();
    t_query();
    report_and_stop();
  end
endmodule : fesp_ctrl_bench
